/* File: rtl/aph_fifo.sv */
// Result buffer with valid/ready on both sides
`timescale 1ns/100ps
module aph_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    // Pointer and fill bookkeeping
    always_comb begin
        in_ready  = (cnt_reg != (AW+1)'(DEPTH));
        out_valid = (cnt_reg != '0);
        out_data  = mem_reg[rd_reg];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_next   = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next   = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next  = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage, one entry per index
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule

/* File: rtl/aph_host_port.sv */
// Converter host port: start strobe, busy, buffered result and data bus drive
`timescale 1ns/100ps
module aph_host_port #(
    parameter bit NARROW = 1'b0
) (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire aph_pkg::aph_host_in_t          host_in,
    input  wire logic [aph_pkg::APH_WIDE_W-1:0] core_code,
    output logic                                busy,
    output logic      [aph_pkg::APH_WIDE_W-1:0] db_out,
    output logic      [aph_pkg::APH_WIDE_W-1:0] db_oe_n,
    output logic                                result_ready,
    output logic                                overrun
);
    aph_pkg::aph_state_t              st_reg, st_next;
    logic [4:0]                       cnt_reg, cnt_next;
    logic                             cs_prev_reg, rd_prev_reg;
    logic                             ovr_reg, ovr_next;
    logic [aph_pkg::APH_WIDE_W-1:0]   db_reg, db_next;
    logic [aph_pkg::APH_WIDE_W-1:0]   code_masked;
    logic                             sel, sel_prev, read_end;
    aph_pkg::aph_result_t             push_data, pop_data;
    logic                             push_valid, push_ready, pop_valid;

    // Narrow variant keeps only the low bits
    assign code_masked = NARROW ? (core_code & ((12'h001 << aph_pkg::APH_NARROW_W) - 12'h001))
                                : core_code;

    assign sel      = !host_in.cs_n && !host_in.rd_n;
    assign sel_prev = !cs_prev_reg && !rd_prev_reg;
    assign read_end = sel_prev && !sel; // one location, each read pops one result

    // Conversion sequencer
    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        push_valid = 1'b0;
        ovr_next   = sel ? 1'b0 : ovr_reg; // Read clears, a lost result below wins
        push_data.code = code_masked;
        case (st_reg)
            aph_pkg::APH_IDLE: begin
                if (!host_in.conversion_start_n) begin // falling edge seen
                    st_next  = aph_pkg::APH_CONVERT;
                    cnt_next = aph_pkg::APH_CNT_ZERO;
                end
            end
            aph_pkg::APH_CONVERT: begin
                if (cnt_reg == aph_pkg::APH_CONV_LAST) begin
                    push_valid = 1'b1; // busy drops with result
                    ovr_next   = ovr_next | !push_ready;
                    st_next    = aph_pkg::APH_WAIT_HIGH;
                end else begin
                    cnt_next = 5'(cnt_reg + 5'h01);
                end
            end
            aph_pkg::APH_WAIT_HIGH: begin
                if (host_in.conversion_start_n) begin
                    st_next = aph_pkg::APH_IDLE;
                end
            end
            default: st_next = aph_pkg::APH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg      <= aph_pkg::APH_IDLE;
            cnt_reg     <= aph_pkg::APH_CNT_ZERO;
            ovr_reg     <= 1'b0;
            cs_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
        end else begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            ovr_reg     <= ovr_next;
            cs_prev_reg <= host_in.cs_n;
            rd_prev_reg <= host_in.rd_n;
        end
    end

    assign busy         = (st_reg == aph_pkg::APH_CONVERT);
    assign result_ready = pop_valid;
    assign overrun      = ovr_reg;

    aph_fifo #(
        .WIDTH (aph_pkg::APH_WIDE_W),
        .DEPTH (aph_pkg::APH_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (push_data.code),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (pop_data.code),
        .out_valid (pop_valid),
        .out_ready (read_end)
    );

    // Output data register holds oldest result
    always_comb begin
        db_next = pop_valid ? pop_data.code : aph_pkg::APH_DATA_ZERO;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            db_reg <= aph_pkg::APH_DATA_ZERO;
        end else begin
            db_reg <= db_next;
        end
    end

    // Bus drive only inside a read
    assign db_out  = db_reg;
    assign db_oe_n = {aph_pkg::APH_WIDE_W{!sel}};

    a_busy_length: assert property (@(posedge clk) disable iff (!resetn)
        $rose(busy) |-> busy [*8] ##1 busy [*4] ##1 !busy)
        else $error("busy length wrong");
    a_busy_push: assert property (@(posedge clk) disable iff (!resetn)
        $fell(busy) |-> $past(push_valid))
        else $error("busy fell without result");
    a_start_busy: assert property (@(posedge clk) disable iff (!resetn)
        (st_reg == aph_pkg::APH_IDLE && !host_in.conversion_start_n) |=> busy)
        else $error("busy did not rise on start");
    a_drive_sel: assert property (@(posedge clk) disable iff (!resetn)
        (db_oe_n[0] == 1'b0) |-> (!host_in.cs_n && !host_in.rd_n))
        else $error("bus driven outside read");
    a_drive_read: assert property (@(posedge clk) disable iff (!resetn)
        (!host_in.cs_n && !host_in.rd_n) |-> (db_oe_n == '0))
        else $error("bus not driven in read");
    a_narrow_bits: assert property (@(posedge clk) disable iff (!resetn)
        NARROW |-> (db_out[aph_pkg::APH_WIDE_W-1:aph_pkg::APH_NARROW_W] == '0))
        else $error("narrow result has high bits");
endmodule

/* File: rtl/aph_pkg.sv */
// Package for the converter parallel host port: constants and carrier types
// Notes on behaviour
// - Busy output falls when a conversion finishes, serving as host interrupt.
// - Result is 10 bits on narrow variant, 12 bits on wide variant.
// - Device drives result onto data lines while output enable strobe is asserted.
// - Device appears as one memory-mapped location in the host map.
// - Conversion starts on start strobe falling edge; busy rises at once.
package aph_pkg;
    localparam int             APH_WIDE_W    = 12;              // Wide variant result
    localparam int             APH_NARROW_W  = 10;              // Narrow variant result
    localparam int             APH_FIFO_DEPTH = 16;             // Result buffer depth
    localparam int             APH_CLK_NS    = 50;              // Host clock period
    localparam int             APH_CONV_NS   = 600;             // Conversion time
    localparam int             APH_CONV_CYC  = (APH_CONV_NS + APH_CLK_NS - 1) / APH_CLK_NS;
    localparam logic [4:0]     APH_CONV_LAST = 5'(APH_CONV_CYC - 1);
    localparam logic [4:0]     APH_CNT_ZERO  = 5'h00;
    localparam logic [11:0]    APH_DATA_ZERO = 12'h000;

    // Result as it travels from the converter core into the buffer
    typedef struct packed {
        logic [APH_WIDE_W-1:0] code;
    } aph_result_t;

    // Host bus pins seen by the device
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic conversion_start_n;
    } aph_host_in_t;

    typedef enum logic [1:0] {
        APH_IDLE,
        APH_CONVERT,
        APH_WAIT_HIGH
    } aph_state_t;
endpackage

/* File: sim/aph_host_model.sv */
// Host-side model: start strobe, decoded reads, busy edge count
`timescale 1ns/100ps
module aph_host_model (
    input  wire logic             clk,
    input  wire logic             busy,
    input  wire logic [11:0]      db_out,
    input  wire logic [11:0]      db_oe_n,
    output aph_pkg::aph_host_in_t host_in,
    output int                    busy_falls
);
    wire logic [11:0] bus_w;
    logic             busy_reg;

    // A data line floats unless the device enables it
    for (genvar i = 0; i < 12; i++) begin : g_bus
        assign bus_w[i] = db_oe_n[i] ? 1'bz : db_out[i];
    end

    initial begin
        host_in = 3'h7;
        busy_falls = 0;
        busy_reg = 1'b0;
    end

    // Edge-sensitive completion input, counts falls of busy
    always @(posedge clk) begin
        if (busy_reg && !busy)
            busy_falls <= busy_falls + 1;
        busy_reg <= busy;
    end

    // Start strobe, host or external timer, low for one edge
    task start_conv();
        @(posedge clk) host_in.conversion_start_n <= 1'b0;
        @(posedge clk) host_in.conversion_start_n <= 1'b1;
    endtask

    // Decoded select with read strobe; pop settles before return
    task access(input logic rd_v, output logic [11:0] d, output logic [11:0] oe);
        @(posedge clk) host_in.cs_n <= 1'b0;
        host_in.rd_n <= rd_v;
        @(posedge clk) d = bus_w;
        oe = db_oe_n;
        host_in.cs_n <= 1'b1;
        host_in.rd_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
endmodule

/* File: sim/tb.sv */
// Testbench for the converter host port with a host-side model
`timescale 1ns/100ps
module tb;
    logic                  clk = 1'b0;
    logic                  resetn = 1'b0;
    logic [11:0]           core_code = 12'h000;
    aph_pkg::aph_host_in_t host_in;
    logic                  busy, result_ready, overrun;
    logic [11:0]           db_out, db_oe_n, db_n, d, oe;
    int                    busy_falls, num_errors = 0, checked = 0;

    always #25 clk = ~clk;

    aph_host_port #(.NARROW(1'b0)) dut_u (.clk(clk), .resetn(resetn), .host_in(host_in),
        .core_code(core_code), .busy(busy), .db_out(db_out), .db_oe_n(db_oe_n),
        .result_ready(result_ready), .overrun(overrun));
    aph_host_port #(.NARROW(1'b1)) dut_n_u (.clk(clk), .resetn(resetn), .host_in(host_in),
        .core_code(core_code), .busy(), .db_out(db_n), .db_oe_n(), .result_ready(),
        .overrun());
    aph_host_model host_u (.clk(clk), .busy(busy), .db_out(db_out), .db_oe_n(db_oe_n),
        .host_in(host_in), .busy_falls(busy_falls));

    task chk(input logic [11:0] got, input logic [11:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            $display("mismatch at %0t: %s", $time, m);
            num_errors++;
        end
    endtask

    // One conversion: busy length and a single completion edge
    task convert(input logic [11:0] code);
        int n;
        int f;
        n = 0;
        f = busy_falls;
        core_code <= code;
        host_u.start_conv();
        repeat (40) @(posedge clk) n += (busy === 1'b1);
        chk(12'(n), 12'(aph_pkg::APH_CONV_CYC), "busy length");
        chk(12'(busy_falls - f), 12'h001, "completion edge");
    endtask

    // Single result, narrow copy, release of the data lines
    task t_single();
        convert(12'hA5C);
        chk(12'(result_ready), 12'h001, "ready after conversion");
        chk(db_n, 12'h25C, "narrow result");
        host_u.access(1'b0, d, oe);
        chk(d, 12'hA5C, "read data");
        chk(oe, 12'h000, "drive during read");
        chk(db_oe_n, 12'hFFF, "release after read");
        chk(12'(result_ready), 12'h000, "empty after read");
        host_u.access(1'b1, d, oe);
        chk(oe, 12'hFFF, "no drive without read strobe");
        $display("test single done");
    endtask

    // Overfill the buffer, then drain it in order and read it empty
    task t_full();
        for (int i = 0; i < 17; i++) convert(12'h100 + 12'(i));
        chk(12'(overrun), 12'h001, "lost result flagged");
        for (int i = 0; i < 16; i++) begin
            host_u.access(1'b0, d, oe);
            chk(d, 12'h100 + 12'(i), "buffer order");
            chk(12'(overrun), 12'h000, "flag cleared by read");
        end
        host_u.access(1'b0, d, oe);
        chk(d, 12'h000, "empty read");
        chk(12'(result_ready), 12'h000, "drained");
        $display("test full done");
    endtask

    task finish_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_single();
        t_full();
        finish_test();
    end
endmodule
